// *** src/spl_consts.svh ***
// Constants for the STS-1 pointer locator and its upstream source
`ifndef SPL_CONSTS_SVH
`define SPL_CONSTS_SVH

// Frame geometry, byte-serial, columns per row and rows per frame
`define SPL_COLS        7'd90
`define SPL_ROWS        4'd9
`define SPL_TOH_COLS    7'd3
`define SPL_PTR_ROW     4'd3
`define SPL_H1_COL      7'd0
`define SPL_H2_COL      7'd1
`define SPL_H3_COL      7'd2
`define SPL_A1_COL      7'd0
`define SPL_A2_COL      7'd1

// Envelope capacity offsets and pointer word layout
`define SPL_EC_LAST     10'd782
`define SPL_PTR_MAX     10'd782
`define SPL_NDF_NORMAL  4'h6
`define SPL_SS_BITS     2'h0
`define SPL_I_MASK      10'h2AA
`define SPL_I_VOTE      3'd3

// Framing bytes, fill byte and missed-frame limit
`define SPL_A1_BYTE     8'hF6
`define SPL_A2_BYTE     8'h28
`define SPL_FILL_BYTE   8'h00
`define SPL_MISS_MAX    2'd2

// Slip buffer
`define SPL_FIFO_DEPTH  16
`define SPL_FIFO_WIDTH  10
`define SPL_LOW_MARK    8

`endif

// *** src/spl_link_if.sv ***
// Byte-serial STS-1 link between the upstream element and the locator
`timescale 1ns/1ps
interface spl_link_if (
  input wire logic clk
);
  logic [7:0] byte_data;
  logic       byte_valid;
  logic       byte_ready;

  // Upstream element drives bytes
  modport src (
    output byte_data,
    output byte_valid,
    input  byte_ready
  );

  // Locator takes bytes
  modport dst (
    input  byte_data,
    input  byte_valid,
    output byte_ready
  );
endinterface

// *** src/spl_locator.sv ***
// Receive-side pointer locator with slip buffer, plus its FIFO
`timescale 1ns/1ps
`include "spl_consts.svh"

module spl_fifo #(
  parameter int WIDTH = `SPL_FIFO_WIDTH,
  parameter int DEPTH = `SPL_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     sys_rst,
  // Fill side
  input  wire logic [WIDTH-1:0]         in_data,
  input  wire logic                     in_valid,
  output logic                          in_ready,
  // Drain side
  output logic [WIDTH-1:0]              out_data,
  output logic                          out_valid,
  input  wire logic                     out_ready,
  output logic [$clog2(DEPTH):0]        level
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  // Honest full and empty straight from the count
  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem[rd_q];
  assign level     = cnt_q;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Storage, no reset needed on the data words
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_q] <= in_data;
    end
  end

  // Pointers wrap at the depth, which need not be a power of two
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop)
      begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module spl_locator
  import spl_pkg::*;
#(
  parameter int FIFO_DEPTH = `SPL_FIFO_DEPTH,
  parameter int LOW_MARK   = `SPL_LOW_MARK
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Link from the upstream element
  spl_link_if.dst         link,
  // Local read side
  input  wire logic       rd_tick,
  output logic [7:0]      out_data,
  output logic            out_valid,
  output logic            out_j1,
  output logic            out_payload,
  output logic            out_dummy,
  // Status
  output logic            in_sync,
  output logic            ptr_bad,
  output logic            ptr_inc,
  output logic [9:0]      ptr_cur
);
  localparam int LW = $clog2(FIFO_DEPTH) + 1;

  spl_align_t  state_q;
  logic [1:0]  miss_q;
  logic [6:0]  col_q;
  logic [3:0]  row_q;
  logic [7:0]  prev_q;
  logic [7:0]  h1_q;
  logic [9:0]  ptr_q;
  logic        ptr_ok_q;
  logic        stuff_q;
  logic [9:0]  ofs_q;
  logic        bad_q;
  logic        inc_q;
  logic [7:0]  odata_q;
  logic        ovalid_q;
  logic        oj1_q;
  logic        opay_q;
  logic        odum_q;
  logic        acc;
  logic        hit;
  logic        at_a2;
  logic        is_ec;
  logic        stuff_slot;
  logic [15:0] pword;
  logic [9:0]  raw;
  logic [9:0]  idiff;
  logic [2:0]  ivotes;
  logic [9:0]  ptr_next;
  spl_entry_t  wr_ent;
  spl_entry_t  rd_ent;
  logic        fifo_rdy;
  logic        fifo_ov;
  logic        pop;
  logic [LW-1:0] fill;

  assign acc   = link.byte_valid & fifo_rdy;
  assign hit   = (prev_q == `SPL_A1_BYTE) && (link.byte_data == `SPL_A2_BYTE);
  assign at_a2 = acc && (row_q == 4'd0) && (col_q == `SPL_A2_COL);
  assign is_ec = (col_q >= `SPL_TOH_COLS);
  assign stuff_slot = stuff_q && (row_q == `SPL_PTR_ROW) && (col_q == `SPL_TOH_COLS);

  // Pointer word assembly and I-bit majority vote against the held pointer
  assign pword    = {h1_q, link.byte_data};
  assign raw      = pword[9:0];
  assign idiff    = (raw ^ ptr_q) & `SPL_I_MASK;
  assign ptr_next = (ptr_q == `SPL_EC_LAST) ? 10'h000 : ptr_q + 10'h001;
  always_comb
  begin
    ivotes = 3'd0;
    for (int i = 0; i < 10; i++)
    begin
      ivotes = ivotes + {2'b00, idiff[i]};
    end
  end

  // Row and column position; a fresh A1/A2 hit re-seats it while hunting
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      col_q  <= 7'd0;
      row_q  <= 4'd0;
      prev_q <= 8'h00;
    end
    else if (acc)
    begin
      prev_q <= link.byte_data;
      if (state_q == SPL_HUNT && hit)
      begin
        col_q <= `SPL_H3_COL;
        row_q <= 4'd0;
      end
      else if (col_q == `SPL_COLS - 7'd1)
      begin
        col_q <= 7'd0;
        row_q <= (row_q == `SPL_ROWS - 4'd1) ? 4'd0 : row_q + 4'd1;
      end
      else
      begin
        col_q <= col_q + 7'd1;
      end
    end
  end

  // Alignment: one confirming frame to lock, two missed frames to drop
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_q <= SPL_HUNT;
      miss_q  <= 2'd0;
    end
    else
    begin
      case (state_q)
        SPL_HUNT:
        begin
          miss_q <= 2'd0;
          if (acc && hit)
          begin
            state_q <= SPL_VERIFY;
          end
        end
        SPL_VERIFY:
        begin
          if (at_a2)
          begin
            state_q <= hit ? SPL_SYNC : SPL_HUNT;
          end
        end
        SPL_SYNC:
        begin
          if (at_a2 && hit)
          begin
            miss_q <= 2'd0;
          end
          else if (at_a2 && miss_q == `SPL_MISS_MAX - 2'd1)
          begin
            state_q <= SPL_HUNT;
            miss_q  <= 2'd0;
          end
          else if (at_a2)
          begin
            miss_q <= miss_q + 2'd1;
          end
        end
        default:
        begin
          state_q <= SPL_HUNT;
        end
      endcase
    end
  end

  // Pointer interpretation, only while aligned
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      h1_q     <= 8'h00;
      ptr_q    <= 10'h000;
      ptr_ok_q <= 1'b0;
      stuff_q  <= 1'b0;
      bad_q    <= 1'b0;
      inc_q    <= 1'b0;
    end
    else
    begin
      bad_q <= 1'b0;
      inc_q <= 1'b0;
      if (state_q != SPL_SYNC)
      begin
        ptr_ok_q <= 1'b0;
        stuff_q  <= 1'b0;
      end
      else if (acc && row_q == `SPL_PTR_ROW && col_q == `SPL_H1_COL)
      begin
        h1_q <= link.byte_data;
      end
      else if (acc && row_q == `SPL_PTR_ROW && col_q == `SPL_H2_COL)
      begin
        if (ptr_ok_q && ivotes >= `SPL_I_VOTE)
        begin
          ptr_q   <= ptr_next;
          stuff_q <= 1'b1;
          inc_q   <= 1'b1;
        end
        else if (raw > `SPL_PTR_MAX)
        begin
          bad_q <= 1'b1;
        end
        else
        begin
          ptr_q    <= raw;
          ptr_ok_q <= 1'b1;
        end
      end
      else if (acc && stuff_slot)
      begin
        stuff_q <= 1'b0;
      end
    end
  end

  // Envelope offset: zero right after H3, 87 per row, wraps at 783
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ofs_q <= 10'h000;
    end
    else if (acc && row_q == `SPL_PTR_ROW && col_q == `SPL_H3_COL)
    begin
      ofs_q <= 10'h000;
    end
    else if (acc && is_ec)
    begin
      ofs_q <= (ofs_q == `SPL_EC_LAST) ? 10'h000 : ofs_q + 10'h001;
    end
  end

  // Each byte enters the slip buffer tagged with its J1 and payload marks
  always_comb
  begin
    wr_ent.data = link.byte_data;
    wr_ent.pay  = is_ec && ptr_ok_q && (state_q == SPL_SYNC) && !stuff_slot;
    wr_ent.j1   = wr_ent.pay && (ofs_q == ptr_q);
  end

  spl_fifo #(
    .WIDTH (`SPL_FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_slip (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_data   (wr_ent),
    .in_valid  (link.byte_valid),
    .in_ready  (fifo_rdy),
    .out_data  (rd_ent),
    .out_valid (fifo_ov),
    .out_ready (pop),
    .level     (fill)
  );

  // Read only while at or above the mark, so equal rates hold the fill still
  assign pop = rd_tick && fifo_ov && (fill >= LW'(LOW_MARK));

  // Local output; a tick that finds the buffer low yields a dummy instead
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      odata_q  <= 8'h00;
      ovalid_q <= 1'b0;
      oj1_q    <= 1'b0;
      opay_q   <= 1'b0;
      odum_q   <= 1'b0;
    end
    else
    begin
      ovalid_q <= rd_tick;
      odata_q  <= pop ? rd_ent.data : `SPL_FILL_BYTE;
      oj1_q    <= pop & rd_ent.j1;
      opay_q   <= pop & rd_ent.pay;
      odum_q   <= rd_tick & ~pop;
    end
  end

  assign link.byte_ready = fifo_rdy;
  assign out_data    = odata_q;
  assign out_valid   = ovalid_q;
  assign out_j1      = oj1_q;
  assign out_payload = opay_q;
  assign out_dummy   = odum_q;
  assign in_sync     = (state_q == SPL_SYNC);
  assign ptr_bad     = bad_q;
  assign ptr_inc     = inc_q;
  assign ptr_cur     = ptr_q;
endmodule

// *** src/spl_pkg.sv ***
// Types shared by the pointer locator ends
package spl_pkg;

  // Frame alignment states
  typedef enum logic [1:0] {
    SPL_HUNT,
    SPL_VERIFY,
    SPL_SYNC
  } spl_align_t;

  // One slip buffer entry: J1 mark, payload mark, byte
  typedef struct packed {
    logic       j1;
    logic       pay;
    logic [7:0] data;
  } spl_entry_t;

endpackage

// *** src/spl_source.sv ***
// Upstream element end: builds STS-1 frames and signals stuff bytes
`timescale 1ns/1ps
`include "spl_consts.svh"

module spl_source
  import spl_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Link towards the locator
  spl_link_if.src         link,
  // User control
  input  wire logic [9:0] cfg_ptr,
  input  wire logic       stuff_req,
  // User payload
  input  wire logic [7:0] pl_data,
  input  wire logic       pl_valid,
  output logic            pl_ready,
  output logic            pl_j1,
  // Status
  output logic [9:0]      ptr_now,
  output logic            stuff_busy
);
  logic [6:0]  col_q;
  logic [3:0]  row_q;
  logic [9:0]  ofs_q;
  logic [9:0]  ptr_q;
  logic        load_q;
  logic        pend_q;
  logic        stuff_q;
  logic        acc;
  logic        is_ec;
  logic        stuff_slot;
  logic        last_byte;
  logic        take;
  logic [9:0]  ptr_next;
  logic [9:0]  eff_ptr;
  logic [15:0] pword;

  assign is_ec      = (col_q >= `SPL_TOH_COLS);
  assign stuff_slot = stuff_q && (row_q == `SPL_PTR_ROW) && (col_q == `SPL_TOH_COLS);
  assign last_byte  = (row_q == `SPL_ROWS - 4'd1) && (col_q == `SPL_COLS - 7'd1);
  assign acc        = link.byte_valid & link.byte_ready;
  assign take       = acc && last_byte && pend_q && !stuff_q;
  assign ptr_next   = (ptr_q == `SPL_EC_LAST) ? 10'h000 : ptr_q + 10'h001;
  assign eff_ptr    = stuff_q ? ptr_next : ptr_q;

  // Pointer word; the stuff frame carries inverted I bits
  assign pword = {`SPL_NDF_NORMAL, `SPL_SS_BITS,
                  ptr_q ^ (stuff_q ? `SPL_I_MASK : 10'h000)};

  // Byte mux: overhead and the stuff byte always valid, payload from user
  always_comb
  begin
    link.byte_data  = 8'h00;
    link.byte_valid = 1'b1;
    if (row_q == 4'd0 && col_q == `SPL_A1_COL)
    begin
      link.byte_data = `SPL_A1_BYTE;
    end
    else if (row_q == 4'd0 && col_q == `SPL_A2_COL)
    begin
      link.byte_data = `SPL_A2_BYTE;
    end
    else if (row_q == `SPL_PTR_ROW && col_q == `SPL_H1_COL)
    begin
      link.byte_data = pword[15:8];
    end
    else if (row_q == `SPL_PTR_ROW && col_q == `SPL_H2_COL)
    begin
      link.byte_data = pword[7:0];
    end
    else if (stuff_slot)
    begin
      link.byte_data = `SPL_FILL_BYTE;
    end
    else if (is_ec)
    begin
      link.byte_data  = pl_data;
      link.byte_valid = pl_valid;
    end
  end

  // The stuff byte takes no user data, so the SPE slides one byte later
  assign pl_ready = is_ec && !stuff_slot && link.byte_ready;
  assign pl_j1    = is_ec && !stuff_slot && (ofs_q == eff_ptr);

  // Frame position and envelope offset
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      col_q <= 7'd0;
      row_q <= 4'd0;
      ofs_q <= 10'h000;
    end
    else if (acc)
    begin
      if (col_q == `SPL_COLS - 7'd1)
      begin
        col_q <= 7'd0;
        row_q <= last_byte ? 4'd0 : row_q + 4'd1;
      end
      else
      begin
        col_q <= col_q + 7'd1;
      end
      if (row_q == `SPL_PTR_ROW && col_q == `SPL_H3_COL)
      begin
        ofs_q <= 10'h000;
      end
      else if (is_ec)
      begin
        ofs_q <= (ofs_q == `SPL_EC_LAST) ? 10'h000 : ofs_q + 10'h001;
      end
    end
  end

  // Stuff scheduling: one stuff frame, then a normal frame at pointer+1
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      load_q  <= 1'b1;
      ptr_q   <= 10'h000;
      pend_q  <= 1'b0;
      stuff_q <= 1'b0;
    end
    else
    begin
      load_q <= 1'b0;
      pend_q <= stuff_req | (pend_q & ~take);
      if (load_q && cfg_ptr <= `SPL_PTR_MAX)
      begin
        ptr_q <= cfg_ptr;
      end
      if (acc && last_byte && stuff_q)
      begin
        stuff_q <= 1'b0;
        ptr_q   <= ptr_next;
      end
      else if (take)
      begin
        stuff_q <= 1'b1;
      end
    end
  end

  assign ptr_now    = ptr_q;
  assign stuff_busy = stuff_q | pend_q;
endmodule

// *** verification/spl_link_props.sv ***
// Checker for the byte link between the upstream element and the locator
`timescale 1ns/1ps
module spl_link_props (
  // Clock and reset
  input wire logic       clk,
  input wire logic       sys_rst,
  // Link signals
  input wire logic [7:0] byte_data,
  input wire logic       byte_valid,
  input wire logic       byte_ready
);
  logic [3:0] row_q;
  logic [6:0] col_q;
  logic [1:0] h1_q;
  logic [9:0] base_q;
  logic       have_q;
  logic       inv_q;
  logic       take;
  logic       h2_take;
  logic       stuffed;
  logic [9:0] word;
  logic [9:0] nxt;

  // Pointer word as it completes on the H2 byte
  assign take    = byte_valid && byte_ready;
  assign h2_take = take && row_q == 4'h3 && col_q == 7'h01;
  assign word    = {h1_q, byte_data};
  assign stuffed = have_q && word == (base_q ^ 10'h2AA);
  assign nxt     = (base_q == 10'h30E) ? 10'h000 : base_q + 10'h001;

  // Frame position; the source restarts at A1 after every reset
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      row_q <= 4'h0;
      col_q <= 7'h00;
    end
    else if (take)
    begin
      col_q <= (col_q == 7'h59) ? 7'h00 : col_q + 7'h01;
      if (col_q == 7'h59)
        row_q <= (row_q == 4'h8) ? 4'h0 : row_q + 4'h1;
    end
  end

  // Pointer history; an inverted word keeps the base so the step can be judged
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      h1_q   <= 2'h0;
      base_q <= 10'h000;
      have_q <= 1'b0;
      inv_q  <= 1'b0;
    end
    else
    begin
      if (take && row_q == 4'h3 && col_q == 7'h00)
        h1_q <= byte_data[1:0];
      if (h2_take)
      begin
        inv_q <= stuffed;
        if (!stuffed)
          base_q <= word;
        have_q <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_stall;
    byte_valid && !byte_ready;
  endsequence

  sequence s_ptr_word;
    h2_take && have_q;
  endsequence

  a_hold_stall: assert property (s_stall |=> byte_valid && $stable(byte_data))
    else $error("link byte changed while stalled");
  a_a1_byte: assert property (byte_valid && row_q == 4'h0 && col_q == 7'h00 |-> byte_data == 8'hF6)
    else $error("first framing byte wrong");
  a_a2_byte: assert property (byte_valid && row_q == 4'h0 && col_q == 7'h01 |-> byte_data == 8'h28)
    else $error("second framing byte wrong");
  a_ndf_bits: assert property (byte_valid && row_q == 4'h3 && col_q == 7'h00 |-> byte_data[7:2] == 6'h18)
    else $error("upper pointer byte flag bits wrong");
  a_h3_zero: assert property (byte_valid && row_q == 4'h3 && col_q == 7'h02 |-> byte_data == 8'h00)
    else $error("byte before offset zero not idle");
  a_ptr_legal: assert property (h2_take |-> word <= 10'h30E || stuffed)
    else $error("pointer out of range on link");
  a_ptr_advance: assert property (s_ptr_word ##0 inv_q |-> word == nxt)
    else $error("pointer did not advance after stuff frame");
  a_ptr_fixed: assert property (s_ptr_word ##0 !inv_q && !stuffed |-> word == base_q)
    else $error("pointer moved without adjustment");
  a_stuff_byte: assert property (byte_valid && inv_q && row_q == 4'h3 && col_q == 7'h03 |-> byte_data == 8'h00)
    else $error("stuff byte not idle");
endmodule

// *** verification/sts1_pointer_locator_tb_top.sv ***
// Testbench: source and locator back to back, plus a second locator fed by the bench
`timescale 1ns/1ps
module sts1_pointer_locator_tb_top;
  logic clk, sys_rst, rd_tick, stuff_req, pl_valid;
  logic [7:0] pl_data, out_data, out_data_b;
  logic [9:0] cfg_ptr, ptr_now, ptr_cur, ptr_cur_b;
  logic out_valid, out_j1, out_payload, out_dummy, in_sync, ptr_inc;
  logic out_valid_b, out_dummy_b, in_sync_b, ptr_bad_b, ptr_inc_b;
  logic saw_inc, saw_inc_b, saw_bad_b, saw_dummy_b, stuff_busy;
  // Start pointers: zero, row ends, wrap boundary, top value
  logic [9:0] ptr_list [6] = '{10'h000, 10'h056, 10'h057, 10'h209, 10'h20A, 10'h30E};
  logic [7:0] dz_b;
  int err_total, n_compared, cyc, opos, j1_cnt, j1_idx, pay_cnt, pay_len, slot_cnt, slot_len, n_dummy;

  spl_link_if i_spl_link_if (.clk(clk));
  spl_link_if i_spl_link_if_b (.clk(clk));
  spl_source i_spl_source (.clk(clk), .sys_rst(sys_rst), .link(i_spl_link_if), .cfg_ptr(cfg_ptr),
    .stuff_req(stuff_req), .pl_data(pl_data), .pl_valid(pl_valid), .pl_ready(), .pl_j1(),
    .ptr_now(ptr_now), .stuff_busy(stuff_busy));
  spl_locator i_spl_locator (.clk(clk), .sys_rst(sys_rst), .link(i_spl_link_if), .rd_tick(rd_tick),
    .out_data(out_data), .out_valid(out_valid), .out_j1(out_j1), .out_payload(out_payload),
    .out_dummy(out_dummy), .in_sync(in_sync), .ptr_bad(), .ptr_inc(ptr_inc), .ptr_cur(ptr_cur));
  spl_locator i_spl_locator_b (.clk(clk), .sys_rst(sys_rst), .link(i_spl_link_if_b), .rd_tick(1'b1),
    .out_data(out_data_b), .out_valid(out_valid_b), .out_j1(), .out_payload(),
    .out_dummy(out_dummy_b), .in_sync(in_sync_b), .ptr_bad(ptr_bad_b), .ptr_inc(ptr_inc_b),
    .ptr_cur(ptr_cur_b));
  spl_link_props i_spl_link_props (.clk(clk), .sys_rst(sys_rst), .byte_data(i_spl_link_if.byte_data),
    .byte_valid(i_spl_link_if.byte_valid), .byte_ready(i_spl_link_if.byte_ready));

  // Free-running local clock, 40 ns period
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic summarize;
    $display("Compared %0d, errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Index of the J1 byte counted from the A1 byte of the frame that holds it
  function automatic int exp_idx(input int p);
    return ((3 + p / 87) % 9) * 90 + 3 + p % 87;
  endfunction

  // Watchdog; a hang counts as a mismatch
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      err_total++;
      summarize();
    end
  end

  // Output stream monitor; values sampled before this edge's updates land
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      j1_cnt <= 0;
      n_dummy <= 0;
      saw_inc <= 1'b0;
    end
    else
    begin
      if (ptr_inc)
        saw_inc <= 1'b1;
      if (out_valid)
      begin
        opos <= (out_data == 8'hF6 && !out_payload) ? 0 : opos + 1;
        slot_cnt <= out_j1 ? 1 : slot_cnt + 1;
        pay_cnt <= out_j1 ? 1 : pay_cnt + int'(out_payload);
        n_dummy <= n_dummy + int'(out_dummy);
        if (out_j1)
        begin
          j1_cnt <= j1_cnt + 1;
          j1_idx <= opos + 1;
          pay_len <= pay_cnt;
          slot_len <= slot_cnt;
        end
      end
    end
    saw_inc_b <= saw_inc_b | ptr_inc_b;
    saw_bad_b <= saw_bad_b | ptr_bad_b;
    saw_dummy_b <= saw_dummy_b | (out_valid_b & out_dummy_b);
    if (out_valid_b && out_dummy_b)
      dz_b <= dz_b | out_data_b;
  end

  // One full source run at a given start pointer, then one increment
  task automatic run_ptr(input logic [9:0] p);
    logic [9:0] q;
    int k;
    q = (p == 10'h30E) ? 10'h000 : p + 10'h001;
    cfg_ptr <= p;
    sys_rst <= 1'b1;
    rd_tick <= 1'b0;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (40) @(posedge clk);
    check(i_spl_link_if.byte_ready, 1'b0);
    rd_tick <= 1'b1;
    while (j1_cnt < 2) @(posedge clk);
    check(in_sync, 1'b1);
    check(ptr_cur, p);
    check(j1_idx, exp_idx(p));
    check(pay_len, 32'h30F);
    check(slot_len, 32'h32A);
    stuff_req <= 1'b1;
    @(posedge clk);
    stuff_req <= 1'b0;
    while (!saw_inc) @(posedge clk);
    check(stuff_busy, 1'b1);
    k = j1_cnt;
    while (j1_cnt < k + 2) @(posedge clk);
    check(ptr_cur, q);
    check(ptr_now, q);
    check(j1_idx, exp_idx(q));
    check(n_dummy, 32'h0);
    check(stuff_busy, 1'b0);
  endtask

  // Bench-built frame on the second link, pointer word given raw
  task automatic send_frame(input logic [9:0] w);
    for (int i = 0; i < 810; i++)
    begin
      i_spl_link_if_b.byte_data <= (i == 0) ? 8'hF6 : (i == 1) ? 8'h28 :
        (i == 270) ? {6'h18, w[9:8]} : (i == 271) ? w[7:0] : (i % 90 < 3) ? 8'h00 : 8'h11;
      i_spl_link_if_b.byte_valid <= 1'b1;
      @(posedge clk);
      while (!i_spl_link_if_b.byte_ready) @(posedge clk);
    end
  endtask

  initial
  begin
    sys_rst = 1'b1;
    rd_tick = 1'b0;
    stuff_req = 1'b0;
    pl_data = 8'h11;
    pl_valid = 1'b1;
    cfg_ptr = 10'h000;
    i_spl_link_if_b.byte_data = 8'h00;
    i_spl_link_if_b.byte_valid = 1'b0;
    {saw_inc_b, saw_bad_b, saw_dummy_b, dz_b} = '0;
    {err_total, n_compared, cyc, opos, pay_cnt, slot_cnt} = '0;
    foreach (ptr_list[i])
      run_ptr(ptr_list[i]);
    // Second locator: steady pointer, increment, out-of-range word, top value
    repeat (3) send_frame(10'h064);
    check(in_sync_b, 1'b1);
    check(ptr_cur_b, 10'h064);
    send_frame(10'h064 ^ 10'h2AA);
    send_frame(10'h065);
    check(saw_inc_b, 1'b1);
    check(ptr_cur_b, 10'h065);
    check(saw_bad_b, 1'b0);
    // Walk to the top value through a word that flips only two I bits each way,
    // so neither step reads as an increment
    send_frame(10'h222);
    send_frame(10'h30E);
    check(ptr_cur_b, 10'h30E);
    send_frame(10'h30F);
    send_frame(10'h30E);
    check(saw_bad_b, 1'b1);
    check(ptr_cur_b, 10'h30E);
    // Far side stalls; buffer falls below the low mark and dummies fill the slots
    @(negedge clk);
    saw_dummy_b = 1'b0;
    dz_b = 8'h00;
    @(posedge clk);
    i_spl_link_if_b.byte_valid <= 1'b0;
    repeat (40) @(posedge clk);
    check(saw_dummy_b, 1'b1);
    check(dz_b, 8'h00);
    summarize();
  end
endmodule
